/* hw/nalu_core.v */
`timescale 1ns/1ns
`include "nalu_defs.vh"

module nalu_core (
	// Operands
	input wire [7:0] opa,
	input wire [7:0] opb,
	input wire cin,
	// Control
	input wire [2:0] fn,
	input wire wide,
	// Result
	output reg [7:0] res,
	output reg cout
);

reg [8:0] full;

always @* begin
	full = {1'h0, opa} + {1'h0, opb} + {8'h00, cin};
	case (fn)
	`NALU_FN_ADD: full = {1'h0, opa} + {1'h0, opb} + {8'h00, cin};
	`NALU_FN_SUB: full = {1'h0, opa} - {1'h0, opb} - {8'h00, cin};
	`NALU_FN_AND: full = {1'h0, opa & opb};
	`NALU_FN_OR: full = {1'h0, opa | opb};
	`NALU_FN_XOR: full = {1'h0, opa ^ opb};
	default: full = {1'h0, opa};
	endcase
	res = full[7:0];
	// Nibble operands arrive zero extended, so bit 4 is their carry
	cout = wide ? full[`NALU_CY_WIDE] : full[`NALU_CY_NIB];
end

endmodule // nalu_core

/* hw/nalu_defs.vh */
//
// Function
// - Nibble add with carry: A plus memory nibble plus carry, carry from result.
// - After nibble add with carry, carry skips a following immediate add, else suppresses skip.
// - Pair add with carry: wide accumulator plus any pair plus carry into accumulator.
// - Reverse pair add with carry: accumulator plus carry added into non-accumulator pair.
// - Nibble subtract: A minus memory nibble, skip on borrow, carry kept.
// - Pair subtract: accumulator minus any pair, skip on borrow, carry kept.
// - Reverse pair subtract: pair minus accumulator into pair, skip on borrow.
// - Nibble subtract with borrow: A minus memory minus carry, carry is borrow.
// - After nibble subtract with borrow, no borrow skips following immediate add.
// - Pair subtract with borrow into accumulator, carry is borrow.
// - Reverse pair subtract with borrow into non-accumulator pair, carry is borrow.
// - Immediate AND of any nibble value with A into A.
// - Memory AND of addressed nibble with A into A.
// - Pair AND with accumulator, into accumulator or reverse into the pair.
// - Immediate OR of any nibble value into A.
// - Memory OR of addressed nibble with A into A.
// - Pair OR with accumulator, into accumulator or reverse into the pair.
// - Immediate exclusive OR of any nibble value with A into A.
// - Memory exclusive OR of addressed nibble with A into A.
// - Pair exclusive OR with accumulator, into accumulator or reverse into pair.
// - Rotate A right one bit through carry.
// - Invert every bit of A in place.
// - Immediate add to A, skip on carry out, carry kept.
//
`ifndef NALU_DEFS_VH
`define NALU_DEFS_VH

// ****************************************
// Operation codes
// ****************************************
`define NALU_OP_NOP 5'h00
`define NALU_OP_ADD_WITH_CARRY_M 5'h01
`define NALU_OP_ADDS_I 5'h02
`define NALU_OP_ADD_WITH_CARRY_P 5'h03
`define NALU_OP_ADD_WITH_CARRY_RP 5'h04
`define NALU_OP_SUBTRACT_SKIP_ON_BORROW_M 5'h05
`define NALU_OP_SUBTRACT_SKIP_ON_BORROW_P 5'h06
`define NALU_OP_SUBTRACT_SKIP_ON_BORROW_RP 5'h07
`define NALU_OP_SUBTRACT_WITH_BORROW_M 5'h08
`define NALU_OP_SUBTRACT_WITH_BORROW_P 5'h09
`define NALU_OP_SUBTRACT_WITH_BORROW_RP 5'h0A
`define NALU_OP_AND_I 5'h0B
`define NALU_OP_AND_M 5'h0C
`define NALU_OP_AND_P 5'h0D
`define NALU_OP_AND_RP 5'h0E
`define NALU_OP_OR_I 5'h0F
`define NALU_OP_OR_M 5'h10
`define NALU_OP_OR_P 5'h11
`define NALU_OP_OR_RP 5'h12
`define NALU_OP_XOR_I 5'h13
`define NALU_OP_XOR_M 5'h14
`define NALU_OP_XOR_P 5'h15
`define NALU_OP_XOR_RP 5'h16
`define NALU_OP_ROTATE_RIGHT_THROUGH_CARRY 5'h17
`define NALU_OP_NOT 5'h18
`define NALU_OP_LOADP 5'h19
`define NALU_OP_LDCY 5'h1A

// ****************************************
// Function select of the arithmetic core
// ****************************************
`define NALU_FN_ADD 3'h0
`define NALU_FN_SUB 3'h1
`define NALU_FN_AND 3'h2
`define NALU_FN_OR 3'h3
`define NALU_FN_XOR 3'h4

// ****************************************
// Pair indices and field positions
// ****************************************
`define NALU_PAIR_ACC 3'h0
`define NALU_PAIR_PTR 3'h1
`define NALU_NIB_LO 3:0
`define NALU_NIB_HI 7:4
`define NALU_CY_WIDE 8
`define NALU_CY_NIB 4
`define NALU_A_LSB 0
`define NALU_A_MSB 3

// ****************************************
// Reset values and chain states
// ****************************************
`define NALU_PAIR_RST 8'h00
`define NALU_NIB_ZERO 4'h0
`define NALU_CY_RST 1'h0
`define NALU_CH_NONE 2'h0
`define NALU_CH_SKIP 2'h1
`define NALU_CH_SUPP 2'h2

`endif

/* hw/nalu_top.v */
`timescale 1ns/1ns
`include "nalu_defs.vh"

module nalu_top (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Operation from the decoder
	input wire op_valid,
	input wire [4:0] op_code,
	input wire [2:0] pair_sel,
	input wire [7:0] imm_data,
	// Nibble read at the memory pointer pair
	input wire [3:0] mem_nibble,
	// Results to the sequencer
	output reg done_r,
	output reg skip_req_r,
	output reg chain_skip_r,
	output reg illegal_r,
	output reg carry_flag_r,
	// Register pairs, pair n at bits 8n+7 to 8n
	output wire [63:0] pairs_flat
);

// ****************************************
// Decode helpers
// ****************************************
function is_rev;
	input [4:0] op;
	begin
		is_rev = (op == `NALU_OP_ADD_WITH_CARRY_RP) || (op == `NALU_OP_SUBTRACT_SKIP_ON_BORROW_RP) ||
			(op == `NALU_OP_SUBTRACT_WITH_BORROW_RP) || (op == `NALU_OP_AND_RP) ||
			(op == `NALU_OP_OR_RP) || (op == `NALU_OP_XOR_RP);
	end
endfunction

function is_pair;
	input [4:0] op;
	begin
		is_pair = (op == `NALU_OP_ADD_WITH_CARRY_P) || (op == `NALU_OP_SUBTRACT_SKIP_ON_BORROW_P) ||
			(op == `NALU_OP_SUBTRACT_WITH_BORROW_P) || (op == `NALU_OP_AND_P) ||
			(op == `NALU_OP_OR_P) || (op == `NALU_OP_XOR_P);
	end
endfunction

// ****************************************
// State
// ****************************************
reg [7:0] pair_r [0:7];
reg [1:0] chain_r;
reg [1:0] chain_nxt;
reg carry_nxt;
reg skip_nxt;
reg chain_skip_nxt;
reg illegal_nxt;
reg wr_en;
reg [2:0] wr_idx;
reg [7:0] wr_val;
reg [7:0] alu_a;
reg [7:0] alu_b;
reg alu_cin;
reg [2:0] alu_fn;
reg alu_wide;
wire [7:0] alu_res;
wire alu_cout;
wire [7:0] acc;
wire [7:0] sel_pair;
wire [3:0] acc_lo;

assign acc = pair_r[`NALU_PAIR_ACC];
assign sel_pair = pair_r[pair_sel];
assign acc_lo = acc[`NALU_NIB_LO];

genvar gi;
generate
	for (gi = 0; gi < 8; gi = gi + 1) begin : g_flat
		assign pairs_flat[gi * 8 + 7:gi * 8] = pair_r[gi];
	end
endgenerate

// ****************************************
// Arithmetic core
// ****************************************
nalu_core u_core (
	.opa(alu_a),
	.opb(alu_b),
	.cin(alu_cin),
	.fn(alu_fn),
	.wide(alu_wide),
	.res(alu_res),
	.cout(alu_cout)
);

// ****************************************
// Operand routing and effects
// ****************************************
always @* begin
	alu_a = {4'h0, acc_lo};
	alu_b = {4'h0, mem_nibble};
	alu_cin = 1'h0;
	alu_fn = `NALU_FN_ADD;
	alu_wide = 1'h0;
	wr_en = 1'h0;
	wr_idx = `NALU_PAIR_ACC;
	wr_val = acc;
	carry_nxt = carry_flag_r;
	skip_nxt = 1'h0;
	chain_skip_nxt = 1'h0;
	illegal_nxt = 1'h0;
	chain_nxt = `NALU_CH_NONE;
	// Wide forms: accumulator against the chosen pair
	if (is_pair(op_code)) begin
		alu_a = acc;
		alu_b = sel_pair;
		alu_wide = 1'h1;
	end
	// Reverse forms: chosen pair against the accumulator, result in the pair
	if (is_rev(op_code)) begin
		alu_a = sel_pair;
		alu_b = acc;
		alu_wide = 1'h1;
		wr_idx = pair_sel;
	end
	if (op_valid) begin
		case (op_code)
		`NALU_OP_NOP: begin
			wr_en = 1'h0;
		end
		`NALU_OP_ADD_WITH_CARRY_M: begin
			alu_cin = carry_flag_r;
			wr_en = 1'h1;
			wr_val = {acc[`NALU_NIB_HI], alu_res[`NALU_NIB_LO]};
			carry_nxt = alu_cout;
			chain_nxt = alu_cout ? `NALU_CH_SKIP : `NALU_CH_SUPP;
		end
		`NALU_OP_ADDS_I: begin
			alu_b = {4'h0, imm_data[`NALU_NIB_LO]};
			if (chain_r == `NALU_CH_SKIP) begin
				// Dropped by the preceding carry or borrow test
				chain_skip_nxt = 1'h1;
			end else begin
				wr_en = 1'h1;
				wr_val = {acc[`NALU_NIB_HI], alu_res[`NALU_NIB_LO]};
				skip_nxt = alu_cout && (chain_r != `NALU_CH_SUPP);
			end
		end
		`NALU_OP_ADD_WITH_CARRY_P: begin
			alu_cin = carry_flag_r;
			wr_en = 1'h1;
			wr_val = alu_res;
			carry_nxt = alu_cout;
		end
		`NALU_OP_ADD_WITH_CARRY_RP: begin
			alu_cin = carry_flag_r;
			wr_en = 1'h1;
			wr_val = alu_res;
			carry_nxt = alu_cout;
		end
		`NALU_OP_SUBTRACT_SKIP_ON_BORROW_M: begin
			alu_fn = `NALU_FN_SUB;
			wr_en = 1'h1;
			wr_val = {acc[`NALU_NIB_HI], alu_res[`NALU_NIB_LO]};
			skip_nxt = alu_cout;
		end
		`NALU_OP_SUBTRACT_SKIP_ON_BORROW_P: begin
			alu_fn = `NALU_FN_SUB;
			wr_en = 1'h1;
			wr_val = alu_res;
			skip_nxt = alu_cout;
		end
		`NALU_OP_SUBTRACT_SKIP_ON_BORROW_RP: begin
			alu_fn = `NALU_FN_SUB;
			wr_en = 1'h1;
			wr_val = alu_res;
			skip_nxt = alu_cout;
		end
		`NALU_OP_SUBTRACT_WITH_BORROW_M: begin
			alu_fn = `NALU_FN_SUB;
			alu_cin = carry_flag_r;
			wr_en = 1'h1;
			wr_val = {acc[`NALU_NIB_HI], alu_res[`NALU_NIB_LO]};
			carry_nxt = alu_cout;
			chain_nxt = alu_cout ? `NALU_CH_SUPP : `NALU_CH_SKIP;
		end
		`NALU_OP_SUBTRACT_WITH_BORROW_P: begin
			alu_fn = `NALU_FN_SUB;
			alu_cin = carry_flag_r;
			wr_en = 1'h1;
			wr_val = alu_res;
			carry_nxt = alu_cout;
		end
		`NALU_OP_SUBTRACT_WITH_BORROW_RP: begin
			alu_fn = `NALU_FN_SUB;
			alu_cin = carry_flag_r;
			wr_en = 1'h1;
			wr_val = alu_res;
			carry_nxt = alu_cout;
		end
		`NALU_OP_AND_I: begin
			alu_fn = `NALU_FN_AND;
			alu_b = {4'h0, imm_data[`NALU_NIB_LO]};
			wr_en = 1'h1;
			wr_val = {acc[`NALU_NIB_HI], alu_res[`NALU_NIB_LO]};
		end
		`NALU_OP_AND_M: begin
			alu_fn = `NALU_FN_AND;
			wr_en = 1'h1;
			wr_val = {acc[`NALU_NIB_HI], alu_res[`NALU_NIB_LO]};
		end
		`NALU_OP_AND_P, `NALU_OP_AND_RP: begin
			alu_fn = `NALU_FN_AND;
			wr_en = 1'h1;
			wr_val = alu_res;
		end
		`NALU_OP_OR_I: begin
			alu_fn = `NALU_FN_OR;
			alu_b = {4'h0, imm_data[`NALU_NIB_LO]};
			wr_en = 1'h1;
			wr_val = {acc[`NALU_NIB_HI], alu_res[`NALU_NIB_LO]};
		end
		`NALU_OP_OR_M: begin
			alu_fn = `NALU_FN_OR;
			wr_en = 1'h1;
			wr_val = {acc[`NALU_NIB_HI], alu_res[`NALU_NIB_LO]};
		end
		`NALU_OP_OR_P, `NALU_OP_OR_RP: begin
			alu_fn = `NALU_FN_OR;
			wr_en = 1'h1;
			wr_val = alu_res;
		end
		`NALU_OP_XOR_I: begin
			alu_fn = `NALU_FN_XOR;
			alu_b = {4'h0, imm_data[`NALU_NIB_LO]};
			wr_en = 1'h1;
			wr_val = {acc[`NALU_NIB_HI], alu_res[`NALU_NIB_LO]};
		end
		`NALU_OP_XOR_M: begin
			alu_fn = `NALU_FN_XOR;
			wr_en = 1'h1;
			wr_val = {acc[`NALU_NIB_HI], alu_res[`NALU_NIB_LO]};
		end
		`NALU_OP_XOR_P, `NALU_OP_XOR_RP: begin
			alu_fn = `NALU_FN_XOR;
			wr_en = 1'h1;
			wr_val = alu_res;
		end
		`NALU_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
			wr_en = 1'h1;
			wr_val = {acc[`NALU_NIB_HI], carry_flag_r,
				acc_lo[`NALU_A_MSB:1]};
			carry_nxt = acc_lo[`NALU_A_LSB];
		end
		`NALU_OP_NOT: begin
			wr_en = 1'h1;
			wr_val = {acc[`NALU_NIB_HI], ~acc_lo};
		end
		`NALU_OP_LOADP: begin
			wr_en = 1'h1;
			wr_idx = pair_sel;
			wr_val = imm_data;
		end
		`NALU_OP_LDCY: begin
			carry_nxt = imm_data[0];
		end
		default: begin
			illegal_nxt = 1'h1;
		end
		endcase
		// Reverse forms may not name the accumulator pair
		if (is_rev(op_code) && (pair_sel == `NALU_PAIR_ACC)) begin
			wr_en = 1'h0;
			carry_nxt = carry_flag_r;
			skip_nxt = 1'h0;
			illegal_nxt = 1'h1;
		end
	end else begin
		// Chain remembered across idle cycles
		chain_nxt = chain_r;
	end
end

// ****************************************
// Registers
// ****************************************
integer i;

always @(posedge mclk) begin
	if (!rst_n) begin
		for (i = 0; i < 8; i = i + 1) begin
			pair_r[i] <= `NALU_PAIR_RST;
		end
		carry_flag_r <= `NALU_CY_RST;
		chain_r <= `NALU_CH_NONE;
		done_r <= 1'h0;
		skip_req_r <= 1'h0;
		chain_skip_r <= 1'h0;
		illegal_r <= 1'h0;
	end else begin
		if (wr_en) begin
			pair_r[wr_idx] <= wr_val;
		end
		carry_flag_r <= carry_nxt;
		chain_r <= chain_nxt;
		done_r <= op_valid;
		skip_req_r <= skip_nxt;
		chain_skip_r <= chain_skip_nxt;
		illegal_r <= illegal_nxt;
	end
end

endmodule // nalu_top

/* testbench/nalu_checker.sv */
`timescale 1ns/1ns
`include "nalu_defs.vh"
// ****************************************
// Port checker
// ****************************************
module nalu_checker (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Operation
	input wire op_valid,
	input wire [4:0] op_code,
	input wire [7:0] imm_data,
	input wire [3:0] mem_nibble,
	// Results
	input wire skip_req_r,
	input wire carry_flag_r,
	input wire [63:0] pairs_flat
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire [3:0] acc = pairs_flat[3:0];
	reg [3:0] a_q, m_q, i_q;
	reg cy_q;
	always @(posedge mclk) begin
		a_q <= acc;
		m_q <= mem_nibble;
		i_q <= imm_data[3:0];
		cy_q <= carry_flag_r;
	end
	not_inv_a: assert property (op_valid && op_code == `NALU_OP_NOT
		|=> acc == ~a_q) else $error("not result wrong");
	rotate_right_through_carry_rot_a: assert property (op_valid && op_code == `NALU_OP_ROTATE_RIGHT_THROUGH_CARRY
		|=> acc == {cy_q, a_q[3:1]} && carry_flag_r == a_q[0])
		else $error("rotate result wrong");
	and_imm_a: assert property (op_valid && op_code == `NALU_OP_AND_I
		|=> acc == (a_q & i_q)) else $error("and imm wrong");
	or_imm_a: assert property (op_valid && op_code == `NALU_OP_OR_I
		|=> acc == (a_q | i_q)) else $error("or imm wrong");
	xor_imm_a: assert property (op_valid && op_code == `NALU_OP_XOR_I
		|=> acc == (a_q ^ i_q)) else $error("xor imm wrong");
	and_mem_a: assert property (op_valid && op_code == `NALU_OP_AND_M
		|=> acc == (a_q & m_q)) else $error("and mem wrong");
	or_mem_a: assert property (op_valid && op_code == `NALU_OP_OR_M
		|=> acc == (a_q | m_q)) else $error("or mem wrong");
	xor_mem_a: assert property (op_valid && op_code == `NALU_OP_XOR_M
		|=> acc == (a_q ^ m_q)) else $error("xor mem wrong");
	subtract_skip_on_borrow_mem_a: assert property (op_valid && op_code == `NALU_OP_SUBTRACT_SKIP_ON_BORROW_M
		|=> acc == a_q - m_q && skip_req_r == (a_q < m_q)
		&& carry_flag_r == cy_q) else $error("subtract skip wrong");
	adds_cy_a: assert property (op_valid && op_code == `NALU_OP_ADDS_I
		|=> carry_flag_r == cy_q) else $error("add imm touched carry");
endmodule // nalu_checker
bind nalu_top nalu_checker chk_u (.mclk(mclk), .rst_n(rst_n),
	.op_valid(op_valid), .op_code(op_code), .imm_data(imm_data),
	.mem_nibble(mem_nibble), .skip_req_r(skip_req_r),
	.carry_flag_r(carry_flag_r), .pairs_flat(pairs_flat));

/* testbench/nalu_mem.sv */
`timescale 1ns/1ns
// ****************************************
// Data memory read at the pointer pair
// ****************************************
module nalu_mem (
	// Clock and strobe
	input wire mclk,
	input wire op_valid,
	// Pointer pair value
	input wire [7:0] ptr,
	// Nibble to the block
	output wire [3:0] mem_nibble
);
	reg [3:0] noise_r = 4'h5;
	// Off-cycle value keeps changing so stale data cannot pass
	always @(posedge mclk) noise_r <= noise_r + 4'h7;
	assign mem_nibble = op_valid ? (ptr[3:0] ^ ptr[7:4]) : noise_r;
endmodule // nalu_mem

/* testbench/testbench.sv */
`timescale 1ns/1ns
`include "nalu_defs.vh"
module testbench;
	reg mclk, rst_n, op_valid;
	reg [4:0] op_code;
	reg [2:0] pair_sel;
	reg [7:0] imm_data;
	wire [3:0] mem_nibble;
	wire done_r, skip_req_r, chain_skip_r, illegal_r, carry_flag_r;
	wire [63:0] pairs_flat;
	integer fails = 0;
	integer compares = 0;
	nalu_top dut_u (.mclk(mclk), .rst_n(rst_n), .op_valid(op_valid),
		.op_code(op_code), .pair_sel(pair_sel), .imm_data(imm_data),
		.mem_nibble(mem_nibble), .done_r(done_r), .skip_req_r(skip_req_r),
		.chain_skip_r(chain_skip_r), .illegal_r(illegal_r),
		.carry_flag_r(carry_flag_r), .pairs_flat(pairs_flat));
	nalu_mem mem_u (.mclk(mclk), .op_valid(op_valid),
		.ptr(pairs_flat[15:8]), .mem_nibble(mem_nibble));
	// ****************************************
	// Shared tasks
	// ****************************************
	task chk(input [63:0] s, input [63:0] e);
		begin
			compares = compares + 1;
			if (s !== e) begin
				fails = fails + 1;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask
	task op(input [4:0] c, input [2:0] s, input [7:0] i);
		begin
			@(posedge mclk);
			#1 op_valid = 1'b1;
			op_code = c;
			pair_sel = s;
			imm_data = i;
			@(posedge mclk);
			#1 op_valid = 1'b0;
		end
	endtask
	task ld(input [2:0] s, input [7:0] v);
		op(`NALU_OP_LOADP, s, v);
	endtask
	// Returns skip, carry, result
	function [9:0] ref_op(input [4:0] c, input [7:0] p, input [7:0] q,
		input ci, input w);
		reg [8:0] t;
		reg [1:0] m;
		begin
			t = 9'h000;
			m = 2'h0;
			case (c)
			`NALU_OP_ADD_WITH_CARRY_M, `NALU_OP_ADD_WITH_CARRY_P, `NALU_OP_ADD_WITH_CARRY_RP: begin
				t = p + q + ci;
				m = 2'h1;
			end
			`NALU_OP_SUBTRACT_SKIP_ON_BORROW_M, `NALU_OP_SUBTRACT_SKIP_ON_BORROW_P, `NALU_OP_SUBTRACT_SKIP_ON_BORROW_RP: begin
				t = p - q;
				m = 2'h2;
			end
			`NALU_OP_SUBTRACT_WITH_BORROW_M, `NALU_OP_SUBTRACT_WITH_BORROW_P, `NALU_OP_SUBTRACT_WITH_BORROW_RP: begin
				t = p - q - ci;
				m = 2'h1;
			end
			`NALU_OP_AND_I, `NALU_OP_AND_M, `NALU_OP_AND_P,
			`NALU_OP_AND_RP: t = p & q;
			`NALU_OP_OR_I, `NALU_OP_OR_M, `NALU_OP_OR_P,
			`NALU_OP_OR_RP: t = p | q;
			default: t = p ^ q;
			endcase
			ref_op = {1'b0, ci, t[7:0]};
			if (m == 2'h1) ref_op[8] = w ? t[8] : t[4];
			if (m == 2'h2) ref_op[9] = w ? t[8] : t[4];
		end
	endfunction
	// ****************************************
	// Scenarios
	// ****************************************
	task t_ops;
		integer i, k, kd;
		reg [9:0] e;
		reg [63:0] x;
		begin
			for (k = 0; k < 2; k = k + 1) for (i = 1; i < 25; i = i + 1) begin
				case (i[4:0])
				`NALU_OP_ADD_WITH_CARRY_P, `NALU_OP_SUBTRACT_SKIP_ON_BORROW_P, `NALU_OP_SUBTRACT_WITH_BORROW_P,
				`NALU_OP_AND_P, `NALU_OP_OR_P, `NALU_OP_XOR_P: kd = 2;
				`NALU_OP_ADD_WITH_CARRY_RP, `NALU_OP_SUBTRACT_SKIP_ON_BORROW_RP, `NALU_OP_SUBTRACT_WITH_BORROW_RP,
				`NALU_OP_AND_RP, `NALU_OP_OR_RP, `NALU_OP_XOR_RP: kd = 3;
				`NALU_OP_AND_I, `NALU_OP_OR_I, `NALU_OP_XOR_I: kd = 1;
				`NALU_OP_ADDS_I, `NALU_OP_ROTATE_RIGHT_THROUGH_CARRY, `NALU_OP_NOT: kd = 4;
				default: kd = 0;
				endcase
				if (kd != 4) begin
					ld(0, 8'h9C);
					ld(1, 8'h35);
					ld(6, 8'h7A);
					op(`NALU_OP_LDCY, 0, k[7:0]);
					op(i[4:0], 6, 8'hE9);
					x = 64'h007A00000000359C;
					if (kd == 0) e = ref_op(i[4:0], 8'h0C, 8'h06, k[0], 0);
					if (kd == 1) e = ref_op(i[4:0], 8'h0C, 8'h09, k[0], 0);
					if (kd == 2) e = ref_op(i[4:0], 8'h9C, 8'h7A, k[0], 1);
					if (kd == 3) e = ref_op(i[4:0], 8'h7A, 8'h9C, k[0], 1);
					if (kd < 2) x[3:0] = e[3:0];
					if (kd == 2) x[7:0] = e[7:0];
					if (kd == 3) x[55:48] = e[7:0];
					chk(pairs_flat, x);
					chk(carry_flag_r, e[8]);
					chk(skip_req_r, e[9]);
				end
			end
			op(`NALU_OP_LDCY, 0, 8'h01);
			op(`NALU_OP_ROTATE_RIGHT_THROUGH_CARRY, 0, 0);
			chk({carry_flag_r, pairs_flat[7:0]}, 9'h09E);
			op(`NALU_OP_NOT, 0, 0);
			chk(pairs_flat[7:0], 8'h91);
			op(`NALU_OP_AND_RP, 0, 0);
			chk({illegal_r, pairs_flat[7:0]}, 9'h191);
		end
	endtask
	task chain(input [4:0] c, input [7:0] a, input [7:0] p);
		reg [9:0] e;
		reg drop;
		reg [3:0] r;
		begin
			ld(0, a);
			ld(1, p);
			op(`NALU_OP_LDCY, 0, 0);
			op(c, 0, 0);
			e = ref_op(c, a, p[3:0] ^ p[7:4], 1'b0, 0);
			drop = (c == `NALU_OP_ADD_WITH_CARRY_M) ? e[8] : !e[8];
			op(`NALU_OP_ADDS_I, 0, 8'h06);
			chk({chain_skip_r, skip_req_r}, {drop, 1'b0});
			// Nibble sum wraps at four bits
			r = drop ? e[3:0] : e[3:0] + 4'h6;
			chk(pairs_flat[3:0], r);
		end
	endtask
	task t_chain;
		begin
			chain(`NALU_OP_ADD_WITH_CARRY_M, 8'h08, 8'h09);
			chain(`NALU_OP_ADD_WITH_CARRY_M, 8'h05, 8'h06);
			chain(`NALU_OP_SUBTRACT_WITH_BORROW_M, 8'h07, 8'h03);
			chain(`NALU_OP_SUBTRACT_WITH_BORROW_M, 8'h02, 8'h03);
			ld(0, 8'h0F);
			op(`NALU_OP_LDCY, 0, 8'h01);
			op(`NALU_OP_ADDS_I, 0, 8'h01);
			chk({skip_req_r, carry_flag_r, pairs_flat[3:0]}, 6'h30);
			chk(done_r, 1'b1);
		end
	endtask
	task test_done;
		begin
			$display("fails=%0d compares=%0d", fails, compares);
			if (fails == 0 && compares > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		#200000;
		fails = fails + 1;
		test_done;
	end
	initial begin
		rst_n = 1'b0;
		op_valid = 1'b0;
		op_code = 5'h00;
		pair_sel = 3'h0;
		imm_data = 8'h00;
		repeat (20) @(posedge mclk);
		#1 rst_n = 1'b1;
		t_ops;
		t_chain;
		test_done;
	end
endmodule // testbench
